// [isol_axil_slave.sv]
`timescale 1ns/1ns
// ****************************************
// AXI4-Lite slave front end
// ****************************************
module isol_axil_slave (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrStb,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk,
    output logic rdStb
);
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0] rResp_reg;
    wire awTake = s_axi_awvalid && !awHeld_reg && !bValid_reg;
    wire wTake = s_axi_wvalid && !wHeld_reg && !bValid_reg;
    wire doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
    wire arTake = s_axi_arvalid && !rValid_reg;
    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;
    assign wrStb = doWrite;
    assign wrAddr = awAddr_reg;
    assign wrData = wData_reg;
    assign wrStrb = wStrb_reg;
    assign rdAddr = s_axi_araddr;
    assign rdStb = arTake;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bValid_reg <= 1'b0;
            bResp_reg <= isol_pkg::RESP_OKAY;
            rValid_reg <= 1'b0;
            rData_reg <= '0;
            rResp_reg <= isol_pkg::RESP_OKAY;
        end else begin
            if (awTake) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg <= wrOk ? isol_pkg::RESP_OKAY : isol_pkg::RESP_SLVERR;
            end else if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
            if (arTake) begin
                rValid_reg <= 1'b1;
                rData_reg <= rdOk ? rdData : '0;
                rResp_reg <= rdOk ? isol_pkg::RESP_OKAY : isol_pkg::RESP_SLVERR;
            end else if (rValid_reg && s_axi_rready) begin
                rValid_reg <= 1'b0;
            end
        end
    end
endmodule

// [isol_checker.sv]
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module isol_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire isol_pkg::isol_sense_t sense,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic outputVoltageOff,
    input wire logic overloadTripFault
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    a_trip_raise: assert property (
        sense.overCurrent |=> overloadTripFault) else $error("trip missing");
    a_trip_held: assert property (
        overloadTripFault |=> overloadTripFault) else $error("trip dropped");
    a_trip_cuts: assert property (
        overloadTripFault |-> ##[0:1] outputVoltageOff)
        else $error("trip kept voltage");
    // Undervoltage must cut the output unless the monitor is blind
    a_uv_cuts: assert property (
        sense.dcLinkLow && !(sense.phaseLoss && sense.extCtrlSupply)
        |-> ##[1:2] outputVoltageOff) else $error("uv kept voltage");
    a_off_cause: assert property (
        outputVoltageOff && !overloadTripFault
        |-> $past(sense.dcLinkLow) || $past(sense.dcLinkLow, 2))
        else $error("voltage off without cause");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_block: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
endmodule

bind isol_status_output isol_checker u_chk (.core_clk, .sys_rst, .sense,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .outputVoltageOff,
    .overloadTripFault);

// [isol_hour_counter.sv]
`timescale 1ns/1ns
// ****************************************
// Hour accumulator
// ****************************************
module isol_hour_counter #(
    parameter longint CYC_PER_HOUR = isol_pkg::HOUR_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic active,
    input wire logic [15:0] limit,
    output logic [15:0] hours,
    output logic exceeded
);
    logic [39:0] tickReg;
    logic [15:0] hoursReg;
    logic exceededReg;
    wire tickDone = (tickReg == 40'(CYC_PER_HOUR - 1));
    // Saturates so the hour count never wraps past the top
    wire hoursFull = (hoursReg == 16'hFFFF);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tickReg <= '0;
            hoursReg <= '0;
            exceededReg <= 1'b0;
        end else begin
            if (active) begin
                tickReg <= tickDone ? '0 : tickReg + 40'd1;
                if (tickDone && !hoursFull) begin
                    hoursReg <= hoursReg + 16'd1;
                end
            end
            exceededReg <= (hoursReg > limit);
        end
    end
    assign hours = hoursReg;
    assign exceeded = exceededReg;
endmodule

// [isol_pkg.sv]
package isol_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_HOUR_LIMIT = 8'h00;
    localparam logic [7:0] ADDR_THERM_PCT = 8'h04;
    localparam logic [7:0] ADDR_SEL_BASE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ADDR_RUN_HOURS = 8'h2C;
    localparam logic [7:0] ADDR_MAINS_HOURS = 8'h30;
    localparam int NUM_OUT = 6;
    localparam logic [15:0] HOUR_LIMIT_RST = 16'h0000;
    localparam logic [15:0] HOUR_LIMIT_MAX = 16'hFFFA;
    localparam logic [7:0] THERM_PCT_RST = 8'h50;
    localparam logic [7:0] THERM_PCT_MAX = 8'h64;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ****************************************
    // Function select codes
    // ****************************************
    localparam logic [7:0] SEL_STOP = 8'h08;
    localparam logic [7:0] SEL_LOWV = 8'h09;
    localparam logic [7:0] SEL_RUN = 8'h11;
    localparam logic [7:0] SEL_MAINS = 8'h12;
    localparam logic [7:0] SEL_THERM = 8'h13;
    localparam logic [7:0] SEL_NONE = 8'h00;
    localparam logic [7:0] SEL_FAULT = 8'h05;
    // ****************************************
    // Timing
    // ****************************************
    localparam longint CLK_HZ = 64'd50_000_000;
    localparam longint HOUR_S = 64'd3600;
    localparam longint HOUR_CYC = CLK_HZ * HOUR_S;
    localparam int STAT_W = 5;
    // Status bit positions
    localparam int ST_LOWV = 0;
    localparam int ST_STOP = 1;
    localparam int ST_RUN = 2;
    localparam int ST_MAINS = 3;
    localparam int ST_THERM = 4;
    localparam int ST_TRIP = 5;
    localparam int ST_OFF = 6;
    // Top member is the MSB, so undervoltage lands in bit 0
    typedef struct packed {
        logic thermWarn;
        logic mainsHours;
        logic runHours;
        logic instStop;
        logic underVolt;
    } isol_flags_t;
    typedef struct packed {
        logic dcLinkLow;
        logic supplyFail;
        logic overVolt;
        logic phaseLoss;
        logic extCtrlSupply;
        logic running;
        logic mainsOn;
        logic overCurrent;
        logic [7:0] loadPct;
    } isol_sense_t;
endpackage

// [isol_status_output.sv]
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// ****************************************
// Inverter status output logic top
// ****************************************
module isol_status_output #(
    parameter longint CYC_PER_HOUR = isol_pkg::HOUR_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire isol_pkg::isol_sense_t sense,
    output logic [4:0] digitalOut,
    output logic relayOut,
    output logic outputVoltageOff,
    output logic overloadTripFault,
    output logic irq
);
    // ****************************************
    // Register state
    // ****************************************
    logic [15:0] hourLimit_reg;
    logic [7:0] thermPct_reg;
    logic [7:0] sel_reg [isol_pkg::NUM_OUT];
    logic [isol_pkg::STAT_W-1:0] irqStat_reg;
    logic [isol_pkg::STAT_W-1:0] irqMask_reg;
    isol_pkg::isol_flags_t flags_reg;
    isol_pkg::isol_flags_t flagsPrev_reg;
    logic tripFault_reg;
    logic voltOff_reg;
    logic [5:0] outs_reg;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic wrOk;
    logic rdOk;
    logic [15:0] runHours;
    logic [15:0] mainsHours;
    logic runExceeded;
    logic mainsExceeded;
    isol_axil_slave bus (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrStb(wrStb),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk),
        .rdStb()
    );
    // ****************************************
    // Time counters
    // ****************************************
    isol_hour_counter #(.CYC_PER_HOUR(CYC_PER_HOUR)) runCnt (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .active(sense.running),
        .limit(hourLimit_reg),
        .hours(runHours),
        .exceeded(runExceeded)
    );
    isol_hour_counter #(.CYC_PER_HOUR(CYC_PER_HOUR)) mainsCnt (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .active(sense.mainsOn),
        .limit(hourLimit_reg),
        .hours(mainsHours),
        .exceeded(mainsExceeded)
    );
    // ****************************************
    // Monitoring
    // ****************************************
    // Phase loss on external control supply blinds the voltage monitors
    wire monBlind = sense.phaseLoss && sense.extCtrlSupply;
    wire lowDcNow = sense.dcLinkLow && !monBlind;
    wire stopNow = (sense.supplyFail || sense.overVolt) && !monBlind;
    wire warnNow = (sense.loadPct > thermPct_reg);
    isol_pkg::isol_flags_t flagsNext;
    assign flagsNext.underVolt = lowDcNow;
    assign flagsNext.instStop = stopNow;
    assign flagsNext.runHours = runExceeded;
    assign flagsNext.mainsHours = mainsExceeded;
    assign flagsNext.thermWarn = warnNow;
    wire [isol_pkg::STAT_W-1:0] flagRise = flags_reg & ~flagsPrev_reg;
    // ****************************************
    // Register decode
    // ****************************************
    wire selHitW = (wrAddr >= isol_pkg::ADDR_SEL_BASE) &&
        (wrAddr < isol_pkg::ADDR_STATUS) && (wrAddr[1:0] == 2'b00);
    wire [2:0] selIdxW = 3'((wrAddr - isol_pkg::ADDR_SEL_BASE) >> 2);
    wire selHitR = (rdAddr >= isol_pkg::ADDR_SEL_BASE) &&
        (rdAddr < isol_pkg::ADDR_STATUS) && (rdAddr[1:0] == 2'b00);
    wire [2:0] selIdxR = 3'((rdAddr - isol_pkg::ADDR_SEL_BASE) >> 2);
    wire hitHour = (wrAddr == isol_pkg::ADDR_HOUR_LIMIT);
    wire hitTherm = (wrAddr == isol_pkg::ADDR_THERM_PCT);
    wire hitIStat = (wrAddr == isol_pkg::ADDR_IRQ_STAT);
    wire hitIMask = (wrAddr == isol_pkg::ADDR_IRQ_MASK);
    assign wrOk = hitHour || hitTherm || hitIStat || hitIMask || selHitW ||
        (wrAddr == isol_pkg::ADDR_STATUS) ||
        (wrAddr == isol_pkg::ADDR_RUN_HOURS) ||
        (wrAddr == isol_pkg::ADDR_MAINS_HOURS);
    wire [15:0] hourWr = wrData[15:0];
    // Out of range values clamp rather than error, so a write lands whenever the byte strobes it needs are set
    wire [15:0] hourClamp = (hourWr > isol_pkg::HOUR_LIMIT_MAX) ?
        isol_pkg::HOUR_LIMIT_MAX : hourWr;
    wire [7:0] thermClamp = (wrData[7:0] > isol_pkg::THERM_PCT_MAX) ?
        isol_pkg::THERM_PCT_MAX : wrData[7:0];
    wire [31:0] statusWord = {25'h0, voltOff_reg, tripFault_reg, flags_reg};
    assign rdOk = selHitR || (rdAddr == isol_pkg::ADDR_HOUR_LIMIT) ||
        (rdAddr == isol_pkg::ADDR_THERM_PCT) ||
        (rdAddr == isol_pkg::ADDR_STATUS) ||
        (rdAddr == isol_pkg::ADDR_IRQ_STAT) ||
        (rdAddr == isol_pkg::ADDR_IRQ_MASK) ||
        (rdAddr == isol_pkg::ADDR_RUN_HOURS) ||
        (rdAddr == isol_pkg::ADDR_MAINS_HOURS);
    assign rdData =
        selHitR ? {24'h0, sel_reg[selIdxR]} :
        (rdAddr == isol_pkg::ADDR_HOUR_LIMIT) ? {16'h0, hourLimit_reg} :
        (rdAddr == isol_pkg::ADDR_THERM_PCT) ? {24'h0, thermPct_reg} :
        (rdAddr == isol_pkg::ADDR_STATUS) ? statusWord :
        (rdAddr == isol_pkg::ADDR_IRQ_STAT) ? {27'h0, irqStat_reg} :
        (rdAddr == isol_pkg::ADDR_IRQ_MASK) ? {27'h0, irqMask_reg} :
        (rdAddr == isol_pkg::ADDR_RUN_HOURS) ? {16'h0, runHours} :
        (rdAddr == isol_pkg::ADDR_MAINS_HOURS) ? {16'h0, mainsHours} :
        32'h0000_0000;
    wire [isol_pkg::STAT_W-1:0] irqClr =
        (wrStb && hitIStat && wrStrb[0]) ? wrData[isol_pkg::STAT_W-1:0] : '0;
    // Set wins over a simultaneous clear
    wire [isol_pkg::STAT_W-1:0] irqStat_next =
        (irqStat_reg & ~irqClr) | flagRise;
    // ****************************************
    // Output routing
    // ****************************************
    logic [5:0] outsNext;
    for (genvar i = 0; i < isol_pkg::NUM_OUT; i++) begin : g_route
        wire [7:0] code = sel_reg[i];
        // Unknown codes drive the output low
        assign outsNext[i] =
            (code == isol_pkg::SEL_STOP) ? flags_reg.instStop :
            (code == isol_pkg::SEL_LOWV) ? flags_reg.underVolt :
            (code == isol_pkg::SEL_RUN) ? flags_reg.runHours :
            (code == isol_pkg::SEL_MAINS) ? flags_reg.mainsHours :
            (code == isol_pkg::SEL_THERM) ? flags_reg.thermWarn :
            (code == isol_pkg::SEL_FAULT) ? tripFault_reg :
            1'b0;
    end
    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hourLimit_reg <= isol_pkg::HOUR_LIMIT_RST;
            thermPct_reg <= isol_pkg::THERM_PCT_RST;
            for (int k = 0; k < isol_pkg::NUM_OUT; k++) begin
                sel_reg[k] <= isol_pkg::SEL_NONE;
            end
            sel_reg[4] <= isol_pkg::SEL_STOP;
            sel_reg[5] <= isol_pkg::SEL_FAULT;
        end else if (wrStb) begin
            if (hitHour && wrStrb[0] && wrStrb[1]) begin
                hourLimit_reg <= hourClamp;
            end
            if (hitTherm && wrStrb[0]) begin
                thermPct_reg <= thermClamp;
            end
            if (selHitW && wrStrb[0] &&
                (selIdxW < 3'(isol_pkg::NUM_OUT))) begin
                sel_reg[selIdxW] <= wrData[7:0];
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqStat_reg <= '0;
            irqMask_reg <= '0;
            flags_reg <= '0;
            flagsPrev_reg <= '0;
            outs_reg <= '0;
            tripFault_reg <= 1'b0;
            voltOff_reg <= 1'b0;
        end else begin
            irqStat_reg <= irqStat_next;
            if (wrStb && hitIMask && wrStrb[0]) begin
                irqMask_reg <= wrData[isol_pkg::STAT_W-1:0];
            end
            flags_reg <= flagsNext;
            flagsPrev_reg <= flags_reg;
            outs_reg <= outsNext;
            // Trip latches until reset; a live current blip must not re-arm
            if (sense.overCurrent) begin
                tripFault_reg <= 1'b1;
            end
            voltOff_reg <= lowDcNow || tripFault_reg ||
                sense.overCurrent;
        end
    end
    assign digitalOut = outs_reg[4:0];
    assign relayOut = outs_reg[5];
    assign outputVoltageOff = voltOff_reg;
    assign overloadTripFault = tripFault_reg;
    assign irq = |(irqStat_reg & irqMask_reg);
endmodule

// [isol_tb.sv]
`timescale 1ns/1ns
// ****************************************
// Testbench
// ****************************************
module testbench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, relayOut, outputVoltageOff, overloadTripFault, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [4:0] digitalOut;
    logic [5:0] termLevel;
    logic [7:0] codes [4];
    isol_pkg::isol_sense_t sense = '0;
    int err_total = 0;
    int n_checks = 0;
    int n;
    always #10 core_clk = ~core_clk;
    // Short hour so the counters trip within a few dozen cycles
    isol_status_output #(.CYC_PER_HOUR(64'd10)) DUT (.core_clk, .sys_rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sense, .digitalOut, .relayOut, .outputVoltageOff,
        .overloadTripFault, .irq);
    isol_terminal_model u_term (.core_clk, .digitalOut, .relayOut,
        .termLevel);
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task tmo;
        err_total++;
        $display("ERROR bus response expected 1 seen 0");
        print_verdict();
    endtask
    task wt(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) tmo();
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) tmo();
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task t_trip;
        @(posedge core_clk);
        sense.overCurrent <= 1'b1;
        @(posedge core_clk);
        sense.overCurrent <= 1'b0;
        wt(4);
        chk("trip fault", 1, overloadTripFault);
        chk("volt off", 1, outputVoltageOff);
        chk("relay", 1, termLevel[5]);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        wt(1);
        chk("trip after reset", 0, overloadTripFault);
        $display("test trip done");
    endtask
    task t_reset;
        axr(isol_pkg::ADDR_HOUR_LIMIT);
        chk("hour limit", 32'h0000_0000, rd);
        axr(isol_pkg::ADDR_THERM_PCT);
        chk("warn level", 32'h0000_0050, rd);
        axr(isol_pkg::ADDR_SEL_BASE + 8'h10);
        chk("out15 select", 32'h0000_0008, rd);
        axr(8'h40);
        chk("unmapped resp", {30'h0, isol_pkg::RESP_SLVERR}, rsp);
        axw(8'h40, 32'h0000_0001);
        chk("unmapped wr resp", {30'h0, isol_pkg::RESP_SLVERR}, rsp);
        $display("test reset values done");
    endtask
    task t_route;
        codes = '{isol_pkg::SEL_STOP, isol_pkg::SEL_STOP, isol_pkg::SEL_LOWV,
            isol_pkg::SEL_THERM};
        for (int i = 0; i < 4; i++) begin
            axw(isol_pkg::ADDR_SEL_BASE, {24'h0, codes[i]});
            axw(isol_pkg::ADDR_SEL_BASE + 8'h14, {24'h0, codes[i]});
            @(posedge core_clk);
            sense.supplyFail <= (i == 0);
            sense.overVolt <= (i == 1);
            sense.dcLinkLow <= (i == 2);
            sense.loadPct <= (i == 3) ? 8'h51 : 8'h50;
            wt(4);
            chk("route on", {i < 2, 3'b000, 1'b1}, termLevel[4:0]);
            chk("relay on", 1, termLevel[5]);
            if (i == 2) chk("uv volt off", 1, outputVoltageOff);
            @(posedge core_clk);
            sense <= '0;
            wt(4);
            chk("route off", 6'h00, termLevel);
        end
        $display("test routing done");
    endtask
    task t_blind;
        axw(isol_pkg::ADDR_SEL_BASE, {24'h0, isol_pkg::SEL_LOWV});
        @(posedge core_clk);
        sense.phaseLoss <= 1'b1;
        sense.extCtrlSupply <= 1'b1;
        sense.dcLinkLow <= 1'b1;
        sense.supplyFail <= 1'b1;
        wt(4);
        chk("blind outputs", 6'h00, termLevel);
        chk("blind volt off", 0, outputVoltageOff);
        @(posedge core_clk);
        sense <= '0;
        $display("test blind monitor done");
    endtask
    task t_hours;
        axw(isol_pkg::ADDR_HOUR_LIMIT, 32'h0000_0001);
        chk("write resp", {30'h0, isol_pkg::RESP_OKAY}, rsp);
        axw(isol_pkg::ADDR_SEL_BASE, {24'h0, isol_pkg::SEL_RUN});
        @(posedge core_clk);
        sense.running <= 1'b1;
        wt(15);
        chk("run at limit", 6'h00, termLevel);
        wt(25);
        chk("run over", 6'h01, termLevel);
        // Shared limit: swap the hour function, never select both
        axw(isol_pkg::ADDR_SEL_BASE, {24'h0, isol_pkg::SEL_MAINS});
        @(posedge core_clk);
        sense.running <= 1'b0;
        wt(4);
        chk("mains idle", 6'h00, termLevel);
        @(posedge core_clk);
        sense.mainsOn <= 1'b1;
        wt(40);
        chk("mains over", 6'h01, termLevel);
        axw(isol_pkg::ADDR_HOUR_LIMIT, 32'h0000_FFFF);
        axr(isol_pkg::ADDR_HOUR_LIMIT);
        chk("hour clamp", 32'h0000_FFFA, rd);
        wt(4);
        chk("below limit", 6'h00, termLevel);
        axw(isol_pkg::ADDR_THERM_PCT, 32'h0000_00C8);
        axr(isol_pkg::ADDR_THERM_PCT);
        chk("level clamp", 32'h0000_0064, rd);
        $display("test hours done");
    endtask
    task t_irq;
        axw(isol_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        axw(isol_pkg::ADDR_IRQ_STAT, 32'h0000_001F);
        @(posedge core_clk);
        sense.dcLinkLow <= 1'b1;
        wt(4);
        chk("irq masked", 0, irq);
        axr(isol_pkg::ADDR_IRQ_STAT);
        chk("irq stat uv", 1, {31'h0, rd[0]});
        axw(isol_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge core_clk);
        sense.dcLinkLow <= 1'b0;
        wt(2);
        chk("irq raised", 1, irq);
        axw(isol_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        wt(2);
        chk("irq cleared", 0, irq);
        $display("test interrupt done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_trip();
        t_reset();
        t_route();
        t_blind();
        t_hours();
        t_irq();
        print_verdict();
    end
endmodule

// [isol_terminal_model.sv]
`timescale 1ns/1ns
// ****************************************
// Output terminals and relay
// ****************************************
module isol_terminal_model (
    input wire logic core_clk,
    input wire logic [4:0] digitalOut,
    input wire logic relayOut,
    output logic [5:0] termLevel
);
    // Terminals settle one clock late, like a real output stage
    always_ff @(posedge core_clk) begin
        termLevel <= {relayOut, digitalOut};
    end
endmodule
